// ### design/sdb_bit_link.sv
// bit level logic of the single wire debug link, device end
`timescale 1ns/1ns
`include "sdb_defs.svh"
module sdb_bit_link #(
  parameter int DATA_W = 8
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic reset_n_i,
  // debug wire pin
  input wire logic pin_in_i,
  output logic pin_out_o,
  output logic pin_oe_o,
  // clock source choice
  input wire logic clk_sel_i,
  input wire logic alt_clk_i,
  // command side
  input wire logic bdc_en_i,
  input wire logic force_bg_i,
  input wire logic bg_cmd_i,
  input wire logic go_i,
  input wire logic cmd_bg_only_i,
  input wire logic tx_valid_i,
  input wire logic [DATA_W-1:0] tx_data_i,
  output logic tx_ready_o,
  output logic [DATA_W-1:0] rx_data_o,
  output logic rx_valid_o,
  output logic abort_o,
  output logic sync_o,
  output logic cmd_ok_o,
  // system side
  input wire logic [15:0] bus_addr_i,
  input wire logic bkpt_en_i,
  input wire logic [15:0] bkpt_addr_i,
  output logic bg_mode_o,
  output logic wdog_off_o,
  output logic wake_o,
  output logic osc_keep_o,
  output logic bkpt_hit_o
);
  localparam int CW = $clog2(DATA_W);

  // pin and alternate clock synchronisers
  logic pin_s1_ff, pin_s2_ff, pin_s3_ff;
  logic alt_s1_ff, alt_s2_ff, alt_s3_ff;
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      pin_s1_ff <= 1'b1;
      pin_s2_ff <= 1'b1;
      pin_s3_ff <= 1'b1;
      alt_s1_ff <= 1'b0;
      alt_s2_ff <= 1'b0;
      alt_s3_ff <= 1'b0;
    end else begin
      pin_s1_ff <= pin_in_i;
      pin_s2_ff <= pin_s1_ff;
      pin_s3_ff <= pin_s2_ff;
      alt_s1_ff <= alt_clk_i;
      alt_s2_ff <= alt_s1_ff;
      alt_s3_ff <= alt_s2_ff;
    end
  end

  // edges only count once the reset strap is taken, so a held strap is no bit
  logic [1:0] strap_ff;
  wire pin_w = pin_s2_ff;
  wire fall_w = pin_s3_ff & ~pin_s2_ff & (strap_ff == `SDB_STRAP_DONE);
  wire tick_w = clk_sel_i ? (alt_s2_ff & ~alt_s3_ff) : 1'b1;

  // bit state machine
  sdb_pkg::sdb_state_t state_ff, nxt_state;
  logic [7:0] cnt_ff;
  logic [9:0] idle_ff;
  logic [DATA_W-1:0] rx_sh_ff, tx_sh_ff;
  logic [CW-1:0] rx_n_ff, tx_n_ff;
  logic tx_pend_ff;

  wire busy_w = tx_pend_ff | (rx_n_ff != '0);
  wire slow_w = (state_ff == sdb_pkg::SDB_SLOW) || (state_ff == sdb_pkg::SDB_SDLY)
    || (state_ff == sdb_pkg::SDB_SRSP);
  wire tmo_w = tick_w & ~fall_w & ~slow_w & (idle_ff == `SDB_TIMEOUT - 10'h1);
  wire abort_w = tmo_w & busy_w;
  wire samp_w = (state_ff == sdb_pkg::SDB_RXB) & tick_w
    & (cnt_ff == `SDB_RX_SAMPLE - 8'h1);
  wire last_rx_w = samp_w & (rx_n_ff == CW'(DATA_W - 1));
  wire tx_end_w = tick_w & (((state_ff == sdb_pkg::SDB_TX1)
    & (cnt_ff == `SDB_TX1_END - 8'h1)) | ((state_ff == sdb_pkg::SDB_TX0)
    & (cnt_ff == `SDB_TX0_END - 8'h1)));
  wire tx_last_w = tx_end_w & (tx_n_ff == CW'(DATA_W - 1));
  wire sync_end_w = (state_ff == sdb_pkg::SDB_SRSP) & tick_w & (cnt_ff == `SDB_SYNC_LOW);

  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      sdb_pkg::SDB_IDLE: begin
        if (fall_w) begin
          if (!tx_pend_ff) begin
            nxt_state = sdb_pkg::SDB_RXB;
          end else if (tx_sh_ff[DATA_W-1]) begin
            nxt_state = sdb_pkg::SDB_TX1;
          end else begin
            nxt_state = sdb_pkg::SDB_TX0;
          end
        end
      end
      sdb_pkg::SDB_RXB: begin
        if (tick_w && !pin_w && cnt_ff == `SDB_SYNC_DET - 8'h1) begin
          nxt_state = sdb_pkg::SDB_SLOW;
        end else if (pin_w && cnt_ff >= `SDB_RX_SAMPLE) begin
          nxt_state = sdb_pkg::SDB_IDLE;
        end
      end
      sdb_pkg::SDB_TX1, sdb_pkg::SDB_TX0: begin
        if (tx_end_w) begin
          nxt_state = sdb_pkg::SDB_IDLE;
        end
      end
      sdb_pkg::SDB_SLOW: begin
        if (pin_w) begin
          nxt_state = sdb_pkg::SDB_SDLY;
        end
      end
      sdb_pkg::SDB_SDLY: begin
        if (tick_w && cnt_ff == `SDB_SYNC_DLY - 8'h1) begin
          nxt_state = sdb_pkg::SDB_SRSP;
        end
      end
      sdb_pkg::SDB_SRSP: begin
        if (sync_end_w) begin
          nxt_state = sdb_pkg::SDB_IDLE;
        end
      end
      default: nxt_state = sdb_pkg::SDB_IDLE;
    endcase
    if (tmo_w) begin
      nxt_state = sdb_pkg::SDB_IDLE;
    end
  end

  // pin drive per state and cycle count
  sdb_pkg::sdb_pin_t nxt_pin;
  always_comb begin
    nxt_pin = '{lvl: 1'b0, oe: 1'b0};
    unique case (nxt_state)
      sdb_pkg::SDB_TX1: begin
        if (state_ff == sdb_pkg::SDB_TX1 && tick_w
            && cnt_ff == `SDB_TX1_PULSE - 8'h1) begin
          nxt_pin = '{lvl: 1'b1, oe: 1'b1};
        end
      end
      sdb_pkg::SDB_TX0: begin
        if (state_ff == sdb_pkg::SDB_TX0 && tick_w
            && cnt_ff == `SDB_TX0_LOW - 8'h1) begin
          nxt_pin = '{lvl: 1'b1, oe: 1'b1};
        end else if (state_ff != sdb_pkg::SDB_TX0 || cnt_ff < `SDB_TX0_LOW) begin
          nxt_pin = '{lvl: 1'b0, oe: 1'b1};
        end else begin
          nxt_pin = '{lvl: 1'b1, oe: 1'b1};
        end
      end
      sdb_pkg::SDB_SRSP: begin
        if (tick_w && cnt_ff == `SDB_SYNC_LOW - 8'h1) begin
          nxt_pin = '{lvl: 1'b1, oe: 1'b1};
        end else if (cnt_ff < `SDB_SYNC_LOW || state_ff != sdb_pkg::SDB_SRSP) begin
          nxt_pin = '{lvl: 1'b0, oe: 1'b1};
        end else begin
          nxt_pin = '{lvl: 1'b1, oe: 1'b1};
        end
      end
      default: nxt_pin = '{lvl: 1'b0, oe: 1'b0};
    endcase
  end

  wire restart_w = (nxt_state != state_ff);
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      state_ff <= sdb_pkg::SDB_IDLE;
      cnt_ff <= 8'h0;
      idle_ff <= 10'h0;
      pin_out_o <= 1'b0;
      pin_oe_o <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      pin_out_o <= nxt_pin.lvl;
      pin_oe_o <= nxt_pin.oe;
      if (restart_w) begin
        cnt_ff <= 8'h0;
      end else if (tick_w && cnt_ff != 8'hff) begin
        cnt_ff <= cnt_ff + 8'h1;
      end
      if (fall_w || slow_w || tmo_w) begin
        idle_ff <= 10'h0;
      end else if (tick_w) begin
        idle_ff <= idle_ff + 10'h1;
      end
    end
  end

  // receive and transmit shifters, msb first
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      rx_sh_ff <= '0;
      rx_n_ff <= '0;
      rx_data_o <= '0;
      rx_valid_o <= 1'b0;
      tx_sh_ff <= '0;
      tx_n_ff <= '0;
      tx_pend_ff <= 1'b0;
      tx_ready_o <= 1'b0;
      abort_o <= 1'b0;
      sync_o <= 1'b0;
    end else begin
      rx_valid_o <= last_rx_w;
      abort_o <= abort_w;
      sync_o <= sync_end_w;
      if (samp_w) begin
        rx_sh_ff <= {rx_sh_ff[DATA_W-2:0], pin_w};
        rx_n_ff <= rx_n_ff + CW'(1);
      end
      if (last_rx_w) begin
        rx_data_o <= {rx_sh_ff[DATA_W-2:0], pin_w};
      end
      if (tmo_w || state_ff == sdb_pkg::SDB_SLOW) begin
        rx_n_ff <= '0;
      end
      if (tmo_w) begin
        tx_pend_ff <= 1'b0;
        tx_n_ff <= '0;
      end else if (tx_end_w) begin
        tx_sh_ff <= {tx_sh_ff[DATA_W-2:0], 1'b0};
        tx_n_ff <= tx_n_ff + CW'(1);
        tx_pend_ff <= ~tx_last_w;
      end else if (tx_valid_i && !tx_pend_ff && state_ff == sdb_pkg::SDB_IDLE) begin
        tx_sh_ff <= tx_data_i;
        tx_n_ff <= '0;
        tx_pend_ff <= 1'b1;
      end
      tx_ready_o <= ~tx_pend_ff & ~tx_valid_i;
    end
  end

  // mode strap, background mode and system hooks
  logic bg_ff;
  wire strap_w = (strap_ff == `SDB_STRAP_AT);
  wire bg_set_w = (force_bg_i & fall_w) | (bg_cmd_i & bdc_en_i);
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      strap_ff <= 2'h0;
      bg_ff <= 1'b0;
      bg_mode_o <= 1'b0;
      wdog_off_o <= 1'b0;
      wake_o <= 1'b0;
      osc_keep_o <= 1'b0;
      bkpt_hit_o <= 1'b0;
      cmd_ok_o <= 1'b0;
    end else begin
      if (strap_ff != `SDB_STRAP_DONE) begin
        strap_ff <= strap_ff + 2'h1;
      end
      if (strap_w) begin
        bg_ff <= ~pin_w;
      end else if (bg_set_w) begin
        bg_ff <= 1'b1;
      end else if (go_i) begin
        bg_ff <= 1'b0;
      end
      bg_mode_o <= bg_ff;
      wdog_off_o <= bg_ff;
      wake_o <= bg_cmd_i & bdc_en_i;
      osc_keep_o <= bdc_en_i;
      bkpt_hit_o <= bkpt_en_i & (bus_addr_i == bkpt_addr_i);
      cmd_ok_o <= ~cmd_bg_only_i | bg_ff;
    end
  end

  // checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);

  sequence s_zero_low;
    (state_ff == sdb_pkg::SDB_IDLE && fall_w && tx_pend_ff && !tx_sh_ff[DATA_W-1]
      && !clk_sel_i);
  endsequence

  a_rx_quiet: assert property (state_ff == sdb_pkg::SDB_RXB |-> !pin_oe_o)
    else $error("pin driven during pod bit");
  a_zero_bit: assert property (s_zero_low ##1 !clk_sel_i [*8] |=>
    pin_oe_o && !pin_out_o)
    else $error("zero bit not held low");
  a_one_pulse: assert property (state_ff == sdb_pkg::SDB_TX1 && tick_w
    && cnt_ff == `SDB_TX1_PULSE - 8'h1 |=> pin_oe_o && pin_out_o)
    else $error("one bit speedup pulse missing");
  a_zero_pulse: assert property (state_ff == sdb_pkg::SDB_TX0 && tick_w
    && cnt_ff == `SDB_TX0_LOW - 8'h1 |=> pin_oe_o && pin_out_o ##1 !pin_oe_o)
    else $error("zero bit speedup pulse wrong");
  a_one_quiet: assert property (state_ff == sdb_pkg::SDB_TX1
    && cnt_ff < `SDB_TX1_PULSE - 8'h1 |=> !pin_oe_o)
    else $error("pin driven before one pulse");
  a_timeout_abort: assert property (tmo_w && busy_w |=> abort_o
    && state_ff == sdb_pkg::SDB_IDLE && !tx_pend_ff && rx_n_ff == '0)
    else $error("timeout did not abort");
  a_sample_pos: assert property ($rose(rx_n_ff != '0) |->
    $past(state_ff) == sdb_pkg::SDB_RXB)
    else $error("sample outside pod bit");
  a_fall_start: assert property (state_ff == sdb_pkg::SDB_IDLE && fall_w
    |=> state_ff != sdb_pkg::SDB_IDLE && cnt_ff == 8'h0)
    else $error("bit start not seen");
  a_wdog_off: assert property (bg_ff |=> wdog_off_o)
    else $error("watchdog active in background");
  a_strap_mode: assert property (strap_w |=> bg_ff == !$past(pin_w))
    else $error("reset strap not taken");
endmodule

// ### pkg/sdb_defs.svh
// timing and reset constants of the debug wire bit link
`ifndef SDB_DEFS_SVH
`define SDB_DEFS_SVH
`define SDB_RX_SAMPLE 8'h0a
`define SDB_TX1_PULSE 8'h07
`define SDB_TX1_END 8'h08
`define SDB_TX0_LOW 8'h0d
`define SDB_TX0_END 8'h0e
`define SDB_SYNC_DET 8'h80
`define SDB_SYNC_DLY 8'h10
`define SDB_SYNC_LOW 8'h80
`define SDB_TIMEOUT 10'h200
`define SDB_STRAP_AT 2'h2
`define SDB_STRAP_DONE 2'h3
`endif

// ### pkg/sdb_pkg.sv
// types of the debug wire bit link
package sdb_pkg;
  typedef enum logic [2:0] {
    SDB_IDLE = 3'h0,
    SDB_RXB = 3'h1,
    SDB_TX1 = 3'h3,
    SDB_TX0 = 3'h2,
    SDB_SLOW = 3'h6,
    SDB_SDLY = 3'h7,
    SDB_SRSP = 3'h5
  } sdb_state_t;
  typedef struct packed {
    logic lvl;
    logic oe;
  } sdb_pin_t;
endpackage

// ### verification/sdb_pod.sv
// debug pod model on the far side of the single wire pin
`timescale 1ns/1ns
module sdb_pod (
  // clock
  input wire logic clk_i,
  // device drive
  input wire logic dev_oe_i,
  input wire logic dev_out_i,
  // resolved wire level
  output logic pin_o
);
  logic lo = 1'b0;
  logic tx = 1'b0;
  int tk = 1;
  int errs = 0;
  // released wire floats to the pull-up level
  assign pin_o = dev_oe_i ? dev_out_i : !lo;
  always @(posedge clk_i) if (dev_oe_i && (lo || tx)) errs <= errs + 1;
  task automatic wt(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  // high phase is left to the pull-up once the pod releases the wire
  task automatic put_bit(input logic b);
    lo <= 1'b1;
    wt(b ? 4 * tk : 13 * tk);
    lo <= 1'b0;
    wt(b ? 18 * tk : 9 * tk);
  endtask
  task automatic get_bit(output logic b);
    lo <= 1'b1;
    wt(2 * tk);
    lo <= 1'b0;
    wt(8 * tk);
    b = pin_o;
    wt(12 * tk);
  endtask
  task automatic put_byte(input logic [7:0] d);
    tx <= 1'b1;
    for (int i = 7; i >= 0; i--) put_bit(d[i]);
    tx <= 1'b0;
  endtask
  // gap that lets the device finish an access
  task automatic hold_off();
    wt(16 * tk);
  endtask
  task automatic get_byte(output logic [7:0] d);
    for (int i = 7; i >= 0; i--) get_bit(d[i]);
  endtask
  // release doubles as the short high pulse
  task automatic sync_req();
    lo <= 1'b1;
    wt(140 * tk);
    lo <= 1'b0;
  endtask
endmodule

// ### verification/tb.sv
// self-checking bench of the debug wire bit link
`timescale 1ns/1ns
module tb;
  logic clk_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic clk_sel_i = 1'b0;
  logic alt_clk_i = 1'b0;
  logic alt_run = 1'b0;
  logic bdc_en_i = 1'b1;
  logic force_bg_i = 1'b0;
  logic bg_cmd_i = 1'b0;
  logic go_i = 1'b0;
  logic cmd_bg_only_i = 1'b0;
  logic tx_valid_i = 1'b0;
  logic [7:0] tx_data_i = 8'h00;
  logic [15:0] bus_addr_i = 16'h0000;
  logic [15:0] bkpt_addr_i = 16'h0000;
  logic bkpt_en_i = 1'b0;
  logic pin, pin_out_o, pin_oe_o, tx_ready_o, rx_valid_o, abort_o, sync_o, cmd_ok_o;
  logic bg_mode_o, wdog_off_o, wake_o, osc_keep_o, bkpt_hit_o;
  logic [7:0] rx_data_o, g;
  int rx_n = 0, ab_n = 0, sy_n = 0, hi_n = 0, run = 0, last_run = 0;
  int miscompares = 0;
  int compares = 0;
  sdb_bit_link #(.DATA_W(8)) sdb_bit_link_inst (
    .clk_i, .reset_n_i, .pin_in_i(pin), .pin_out_o, .pin_oe_o, .clk_sel_i, .alt_clk_i,
    .bdc_en_i, .force_bg_i, .bg_cmd_i, .go_i, .cmd_bg_only_i, .tx_valid_i, .tx_data_i,
    .tx_ready_o, .rx_data_o, .rx_valid_o, .abort_o, .sync_o, .cmd_ok_o, .bus_addr_i,
    .bkpt_en_i, .bkpt_addr_i, .bg_mode_o, .wdog_off_o, .wake_o, .osc_keep_o, .bkpt_hit_o
  );
  sdb_pod sdb_pod_inst (.clk_i, .dev_oe_i(pin_oe_o), .dev_out_i(pin_out_o), .pin_o(pin));
  always #2 clk_i = ~clk_i;
  always @(posedge clk_i) if (alt_run) alt_clk_i <= ~alt_clk_i;
  // event counters and device low-drive run length
  always @(posedge clk_i) begin
    if (rx_valid_o === 1'b1) rx_n <= rx_n + 1;
    if (abort_o === 1'b1) ab_n <= ab_n + 1;
    if (sync_o === 1'b1) sy_n <= sy_n + 1;
    if (pin_oe_o === 1'b1 && pin_out_o === 1'b1) hi_n <= hi_n + 1;
    if (pin_oe_o === 1'b1 && pin_out_o === 1'b0) run <= run + 1;
    else if (run != 0) begin
      last_run <= run;
      run <= 0;
    end
  end
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic end_sim();
    chk("pin clash", sdb_pod_inst.errs, 0);
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic wait_ev(ref int c, input int c0, input int n, output int k);
    for (k = 0; k < n && c == c0; k++) cyc(1);
    if (k == n) begin
      chk("event wait", 0, 1);
      end_sim();
    end
  endtask
  task automatic do_reset(input logic low);
    reset_n_i <= 1'b0;
    sdb_pod_inst.lo <= low;
    cyc(12);
    reset_n_i <= 1'b1;
    cyc(6);
    chk("bg_mode", bg_mode_o, low);
    chk("wdog_off", wdog_off_o, low);
    sdb_pod_inst.lo <= 1'b0;
    cyc(4);
  endtask
  task automatic pulse_go();
    go_i <= 1'b1;
    cyc(1);
    go_i <= 1'b0;
    cyc(3);
  endtask
  task automatic rx_byte(input logic [7:0] d);
    int r0;
    r0 = rx_n;
    sdb_pod_inst.put_byte(d);
    chk("rx count", rx_n, r0 + 1);
    chk("rx data", rx_data_o, d);
  endtask
  task automatic t_strap();
    do_reset(1'b1);
    pulse_go();
    chk("bg after go", bg_mode_o, 0);
    rx_byte(8'h5a);
    do_reset(1'b0);
    $display("test strap done");
  endtask
  task automatic t_mode();
    force_bg_i <= 1'b1;
    rx_byte(8'h90);
    force_bg_i <= 1'b0;
    chk("forced bg", bg_mode_o, 1);
    cmd_bg_only_i <= 1'b1;
    cyc(3);
    chk("cmd ok bg", cmd_ok_o, 1);
    pulse_go();
    chk("cmd ok run", cmd_ok_o, 0);
    cmd_bg_only_i <= 1'b0;
    bg_cmd_i <= 1'b1;
    cyc(1);
    bg_cmd_i <= 1'b0;
    cyc(1);
    chk("wake", wake_o, 1);
    cyc(2);
    chk("bg by cmd", bg_mode_o, 1);
    bdc_en_i <= 1'b0;
    cyc(3);
    chk("osc off", osc_keep_o, 0);
    bdc_en_i <= 1'b1;
    bkpt_en_i <= 1'b1;
    bus_addr_i <= 16'h1234;
    bkpt_addr_i <= 16'h1234;
    cyc(3);
    chk("osc on", osc_keep_o, 1);
    chk("bkpt hit", bkpt_hit_o, 1);
    bus_addr_i <= 16'h1235;
    cyc(3);
    chk("bkpt miss", bkpt_hit_o, 0);
    pulse_go();
    $display("test mode done");
  endtask
  task automatic t_tx(input logic [7:0] d);
    int h0;
    chk("tx ready", tx_ready_o, 1);
    tx_valid_i <= 1'b1;
    tx_data_i <= d;
    cyc(1);
    tx_valid_i <= 1'b0;
    sdb_pod_inst.hold_off();
    h0 = hi_n;
    sdb_pod_inst.get_byte(g);
    chk("tx data", g, d);
    chk("speedup pulses", hi_n, h0 + 8);
    chk("zero low run", last_run, 13);
  endtask
  task automatic t_timeout();
    int a0, r0, k;
    a0 = ab_n;
    r0 = rx_n;
    repeat (3) sdb_pod_inst.put_bit(1'b1);
    wait_ev(ab_n, a0, 700, k);
    chk("abort gap", (k >= 485 && k <= 500), 1);
    chk("no rx", rx_n, r0);
    chk("mode kept", bg_mode_o, 0);
    $display("test timeout done");
  endtask
  task automatic t_sync();
    int s0, k;
    s0 = sy_n;
    sdb_pod_inst.sync_req();
    wait_ev(sy_n, s0, 400, k);
    chk("sync low", last_run, 128);
    $display("test sync done");
  endtask
  initial begin
    t_strap();
    t_mode();
    rx_byte(8'ha5);
    rx_byte(8'h01);
    rx_byte(8'h80);
    $display("test rx done");
    t_tx(8'h3c);
    t_tx(8'he2);
    $display("test tx done");
    clk_sel_i <= 1'b1;
    alt_run <= 1'b1;
    sdb_pod_inst.tk = 2;
    rx_byte(8'h96);
    sdb_pod_inst.tk = 1;
    clk_sel_i <= 1'b0;
    alt_run <= 1'b0;
    cyc(8);
    $display("test alt clock done");
    t_timeout();
    t_sync();
    end_sim();
  end
endmodule
